/* pkg/esie_pkg.sv */
// Purpose: constants for the event status information encoder
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   codes are the values carried in the outgoing status block
package esie_pkg;
	// register byte offsets
	localparam logic [5:0] ESIE_OFS_CTRL   = 6'h00;
	localparam logic [5:0] ESIE_OFS_SEND   = 6'h04;
	localparam logic [5:0] ESIE_OFS_PWR    = 6'h08;
	localparam logic [5:0] ESIE_OFS_MEDIA  = 6'h0c;
	localparam logic [5:0] ESIE_OFS_BUSY   = 6'h10;
	localparam logic [5:0] ESIE_OFS_ISTAT  = 6'h14;
	localparam logic [5:0] ESIE_OFS_ICLR   = 6'h18;
	localparam logic [5:0] ESIE_OFS_IEN    = 6'h1c;
	localparam logic [5:0] ESIE_OFS_STATE  = 6'h20;

	// field positions
	localparam int ESIE_CTRL_UNSOL_BIT = 0;
	localparam int ESIE_SEND_CLASS_LSB = 0;
	localparam int ESIE_EVT_LSB        = 0;
	localparam int ESIE_STS_LSB        = 8;
	localparam int ESIE_START_LSB      = 8;
	localparam int ESIE_END_LSB        = 16;
	localparam int ESIE_TIME_LSB       = 16;
	localparam int ESIE_DOOR_BIT       = 0;
	localparam int ESIE_PRESENT_BIT    = 1;

	// interrupt source bits
	localparam int ESIE_IRQ_W          = 5;
	localparam int ESIE_IRQ_SENT       = 0;
	localparam int ESIE_IRQ_DISABLED   = 1;
	localparam int ESIE_IRQ_RESERVED   = 2;
	localparam int ESIE_IRQ_MEDIA_CHG  = 3;
	localparam int ESIE_IRQ_OVERRUN    = 4;

	// send class selectors written by software
	localparam logic [1:0] ESIE_CLS_POWER = 2'h1;
	localparam logic [1:0] ESIE_CLS_MEDIA = 2'h2;
	localparam logic [1:0] ESIE_CLS_BUSY  = 2'h3;

	// fixed sense values of an event report
	localparam logic [7:0] ESIE_STATUS_CHECK  = 8'h02;
	localparam logic [7:0] ESIE_KEY_UNIT_ATTN = 8'h06;
	localparam logic [7:0] ESIE_CODE_EVENT    = 8'h7f;
	localparam logic [7:0] ESIE_QUAL_POWER    = 8'h02;
	localparam logic [7:0] ESIE_QUAL_MEDIA    = 8'h04;
	localparam logic [7:0] ESIE_QUAL_BUSY     = 8'h06;

	// highest defined codes per field, and the lowest power status code
	localparam logic [7:0] ESIE_PWR_EVT_MAX   = 8'h02;
	localparam logic [7:0] ESIE_PWR_STS_MIN   = 8'h01;
	localparam logic [7:0] ESIE_PWR_STS_MAX   = 8'h03;
	localparam logic [7:0] ESIE_MEDIA_EVT_MAX = 8'h03;
	localparam logic [7:0] ESIE_BUSY_EVT_MAX  = 8'h01;
	localparam logic [7:0] ESIE_BUSY_STS_MAX  = 8'h03;

	// reset values
	localparam logic [31:0] ESIE_RST_WORD = 32'h0000_0000;

	typedef enum logic [2:0]
	{
		ESIE_IDLE  = 3'b001,
		ESIE_CHECK = 3'b010,
		ESIE_EMIT  = 3'b100
	} esie_state_e;
endpackage

/* design/esie_encoder.sv */
// Purpose: builds the four-byte information field of an unsolicited
//          event status report for power, media and busy events
// Assumes: inputs synchronous to clk; software fills the class
//          register, then writes the send register with the class
// Notes:   reports with reserved codes are refused, never emitted
`timescale 1ns/10ps
module esie_encoder
	import esie_pkg::*;
#(
	parameter bit MULTI_SLOT         = 1'b1,
	parameter bit SENSE_WHILE_OPEN   = 1'b1
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [5:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rd_data,
	input  wire logic        door_open,
	input  wire logic        media_sensed,
	output logic             rpt_valid,
	output logic      [7:0]  rpt_status,
	output logic      [7:0]  rpt_sense_key,
	output logic      [7:0]  rpt_sense_code,
	output logic      [7:0]  rpt_qualifier,
	output logic      [31:0] rpt_info,
	output logic             irq
);

	esie_state_e state;
	esie_state_e next_state;

	logic                  unsol_en;
	logic [1:0]            send_class;
	logic [15:0]           pwr_word;
	logic [23:0]           media_word;
	logic [31:0]           busy_word;
	logic [ESIE_IRQ_W-1:0] irq_stat;
	logic [ESIE_IRQ_W-1:0] irq_en;
	logic [ESIE_IRQ_W-1:0] irq_set;
	logic [ESIE_IRQ_W-1:0] irq_clr;
	logic [7:0]            rpt_count;
	logic                  door_q;
	logic                  present_q;
	logic                  present_now;
	logic                  codes_ok;
	logic [7:0]            next_qual;
	logic [31:0]           next_info;
	logic                  send_wr;

	// write to the send register starts a report
	assign send_wr = wr_en && (addr == ESIE_OFS_SEND);

	// media-present follows its own sensor, the door only masks it
	// when the drive cannot sense through an open door
	always_comb
	begin
		present_now = media_sensed;
		if (!SENSE_WHILE_OPEN && door_open)
			present_now = 1'b0;
	end

	// control register: unsolicited enable set by software
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			unsol_en <= 1'b0;
		else if (wr_en && addr == ESIE_OFS_CTRL)
			unsol_en <= wr_data[ESIE_CTRL_UNSOL_BIT];
	end

	// class field registers; held while a report is being built
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pwr_word   <= ESIE_RST_WORD[15:0];
			media_word <= ESIE_RST_WORD[23:0];
			busy_word  <= ESIE_RST_WORD;
		end
		else if (wr_en && state == ESIE_IDLE)
		begin
			if (addr == ESIE_OFS_PWR)
				pwr_word <= wr_data[15:0];
			if (addr == ESIE_OFS_MEDIA)
				media_word <= wr_data[23:0];
			if (addr == ESIE_OFS_BUSY)
				busy_word <= wr_data;
		end
	end

	// class latched at the send write
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			send_class <= 2'h0;
		else if (send_wr && state == ESIE_IDLE)
			send_class <= wr_data[ESIE_SEND_CLASS_LSB +: 2];
	end

	// code check: a reserved value anywhere refuses the whole report
	always_comb
	begin
		codes_ok = 1'b0;
		case (send_class)
			ESIE_CLS_POWER:
			begin
				codes_ok =
					(pwr_word[ESIE_EVT_LSB +: 8] <= ESIE_PWR_EVT_MAX) &&
					(pwr_word[ESIE_STS_LSB +: 8] >= ESIE_PWR_STS_MIN) &&
					(pwr_word[ESIE_STS_LSB +: 8] <= ESIE_PWR_STS_MAX);
			end
			ESIE_CLS_MEDIA:
			begin
				codes_ok =
					(media_word[ESIE_EVT_LSB +: 8] <= ESIE_MEDIA_EVT_MAX);
			end
			ESIE_CLS_BUSY:
			begin
				codes_ok =
					(busy_word[ESIE_EVT_LSB +: 8] <= ESIE_BUSY_EVT_MAX) &&
					(busy_word[ESIE_STS_LSB +: 8] <= ESIE_BUSY_STS_MAX);
			end
			default:
			begin
				codes_ok = 1'b0; // class zero is no event class
			end
		endcase
	end

	// information field and qualifier per class
	always_comb
	begin
		next_info = 32'h0;
		next_qual = 8'h0;
		case (send_class)
			ESIE_CLS_POWER:
			begin
				next_qual = ESIE_QUAL_POWER;
				next_info[31:24] = pwr_word[ESIE_EVT_LSB +: 8];
				next_info[23:16] = pwr_word[ESIE_STS_LSB +: 8];
				next_info[15:0]  = 16'h0;
			end
			ESIE_CLS_MEDIA:
			begin
				next_qual = ESIE_QUAL_MEDIA;
				next_info[31:24] = media_word[ESIE_EVT_LSB +: 8];
				next_info[23:16] = 8'h0;
				next_info[16 + ESIE_DOOR_BIT]    = door_open;
				next_info[16 + ESIE_PRESENT_BIT] = present_now;
				if (MULTI_SLOT)
				begin
					next_info[15:8] =
						media_word[ESIE_START_LSB +: 8];
					next_info[7:0] = media_word[ESIE_END_LSB +: 8];
				end
			end
			ESIE_CLS_BUSY:
			begin
				next_qual = ESIE_QUAL_BUSY;
				next_info[31:24] = busy_word[ESIE_EVT_LSB +: 8];
				next_info[23:16] = busy_word[ESIE_STS_LSB +: 8];
				next_info[15:0]  = busy_word[ESIE_TIME_LSB +: 16];
			end
			default:
			begin
				next_info = 32'h0;
				next_qual = 8'h0;
			end
		endcase
	end

	// sequencer: idle, check for one cycle, emit for one cycle
	always_comb
	begin
		next_state = state;
		case (state)
			ESIE_IDLE:
				if (send_wr)
					next_state = ESIE_CHECK;
			ESIE_CHECK:
				if (codes_ok && unsol_en)
					next_state = ESIE_EMIT;
				else
					next_state = ESIE_IDLE;
			ESIE_EMIT:  next_state = ESIE_IDLE;
			default:    next_state = ESIE_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state <= ESIE_IDLE;
		else
			state <= next_state;
	end

	// report outputs; fields stay until the next report replaces them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rpt_valid      <= 1'b0;
			rpt_status     <= 8'h0;
			rpt_sense_key  <= 8'h0;
			rpt_sense_code <= 8'h0;
			rpt_qualifier  <= 8'h0;
			rpt_info       <= 32'h0;
		end
		else
		begin
			rpt_valid <= 1'b0;
			if (state == ESIE_CHECK && codes_ok && unsol_en)
			begin
				rpt_valid      <= 1'b1;
				rpt_status     <= ESIE_STATUS_CHECK;
				rpt_sense_key  <= ESIE_KEY_UNIT_ATTN;
				rpt_sense_code <= ESIE_CODE_EVENT;
				rpt_qualifier  <= next_qual;
				rpt_info       <= next_info;
			end
		end
	end

	// wrap-around count of reports sent, for software bookkeeping
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rpt_count <= 8'h0;
		else if (state == ESIE_CHECK && codes_ok && unsol_en)
			rpt_count <= rpt_count + 8'h1;
	end

	// previous door and media levels, to spot a media status change
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			door_q    <= 1'b0;
			present_q <= 1'b0;
		end
		else
		begin
			door_q    <= door_open;
			present_q <= present_now;
		end
	end

	// interrupt sources
	always_comb
	begin
		irq_set = '0;
		irq_set[ESIE_IRQ_SENT] =
			(state == ESIE_CHECK) && codes_ok && unsol_en;
		irq_set[ESIE_IRQ_DISABLED] =
			(state == ESIE_CHECK) && codes_ok && !unsol_en;
		irq_set[ESIE_IRQ_RESERVED] = (state == ESIE_CHECK) && !codes_ok;
		irq_set[ESIE_IRQ_MEDIA_CHG] =
			(door_q != door_open) || (present_q != present_now);
		// a send while busy is dropped, so say so
		irq_set[ESIE_IRQ_OVERRUN] = send_wr && (state != ESIE_IDLE);
	end

	assign irq_clr = (wr_en && addr == ESIE_OFS_ICLR) ?
		wr_data[ESIE_IRQ_W-1:0] : '0;

	// sticky status bits; a set in the clearing cycle is kept
	genvar gi;
	generate
		for (gi = 0; gi < ESIE_IRQ_W; gi++)
		begin : g_sticky
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					irq_stat[gi] <= 1'b0;
				else if (irq_set[gi])
					irq_stat[gi] <= 1'b1;
				else if (irq_clr[gi])
					irq_stat[gi] <= 1'b0;
			end
		end
	endgenerate

	// interrupt enable register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_en <= '0;
		else if (wr_en && addr == ESIE_OFS_IEN)
			irq_en <= wr_data[ESIE_IRQ_W-1:0];
	end

	// level interrupt; one cycle behind the status bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_en);
	end

	// read port: data in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_data <= 32'h0;
		end
		else
		begin
			rd_data <= 32'h0;
			if (rd_en)
			begin
				case (addr)
					ESIE_OFS_CTRL:  rd_data <= {31'h0, unsol_en};
					ESIE_OFS_SEND:  rd_data <= {30'h0, send_class};
					ESIE_OFS_PWR:   rd_data <= {16'h0, pwr_word};
					ESIE_OFS_MEDIA: rd_data <= {8'h0, media_word};
					ESIE_OFS_BUSY:  rd_data <= busy_word;
					ESIE_OFS_ISTAT:
						rd_data <= {{(32-ESIE_IRQ_W){1'b0}}, irq_stat};
					ESIE_OFS_IEN:
						rd_data <= {{(32-ESIE_IRQ_W){1'b0}}, irq_en};
					ESIE_OFS_STATE:
						rd_data <= {16'h0, rpt_count, 3'h0,
							state != ESIE_IDLE, 2'h0,
							present_now, door_open};
					default:        rd_data <= 32'h0; // clear reg too
				endcase
			end
		end
	end

endmodule

/* verif/esie_chk.sv */
// Purpose: assertions on the report outputs of the encoder
// Assumes: one clock, asynchronous reset active high
// Notes:   report fields are judged only in the rpt_valid cycle
`timescale 1ns/10ps
module esie_chk
	import esie_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [5:0]  addr,
	input wire logic        wr_en,
	input wire logic        door_open,
	input wire logic        media_sensed,
	input wire logic        rpt_valid,
	input wire logic [7:0]  rpt_status,
	input wire logic [7:0]  rpt_sense_key,
	input wire logic [7:0]  rpt_sense_code,
	input wire logic [7:0]  rpt_qualifier,
	input wire logic [31:0] rpt_info
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// short names for the qualifier, the information bytes and the send strobe
	wire logic [7:0] q  = rpt_qualifier;
	wire logic [7:0] ev = rpt_info[31:24];
	wire logic [7:0] st = rpt_info[23:16];
	wire logic       snd = wr_en && addr == ESIE_OFS_SEND;

	a_fixed_sense: assert property (rpt_valid |->
		{rpt_status, rpt_sense_key, rpt_sense_code} == 24'h02067f)
		else $error("fixed sense bytes wrong");
	a_class_qual: assert property (rpt_valid |->
		q inside {8'h02, 8'h04, 8'h06})
		else $error("qualifier not a class");
	a_power_codes: assert property (rpt_valid && q == 8'h02 |->
		ev <= 8'h02 && st inside {[8'h01:8'h03]} && rpt_info[15:0] == 0)
		else $error("power report malformed");
	a_media_codes: assert property (rpt_valid && q == 8'h04 |->
		ev <= 8'h03 && st[7:2] == 6'h00)
		else $error("media report malformed");
	a_busy_codes: assert property (rpt_valid && q == 8'h06 |->
		ev <= 8'h01 && st <= 8'h03)
		else $error("busy report malformed");
	a_door_bit: assert property (rpt_valid && q == 8'h04 |->
		st[0] == $past(door_open))
		else $error("door bit wrong");
	a_present_bit: assert property (rpt_valid && q == 8'h04 |->
		st[1] == $past(media_sensed))
		else $error("present bit wrong");
	a_send_cause: assert property (rpt_valid |->
		$past(snd, 2))
		else $error("report without send two cycles before");

	c_power: cover property (rpt_valid && q == 8'h02);
	c_media: cover property (rpt_valid && q == 8'h04);
	c_busy: cover property (rpt_valid && q == 8'h06);
endmodule

/* verif/esie_host_model.sv */
// Purpose: initiator side, collects emitted status blocks
// Assumes: a block is taken in the cycle of rpt_valid
// Notes:   keeps the last block only, enough for one-at-a-time use
`timescale 1ns/10ps
module esie_host_model
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        rpt_valid,
	input wire logic [31:0] rpt_info,
	output logic     [31:0] blk_info,
	output logic     [7:0]  blk_count
);
	// latch each block as it arrives and count them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			blk_info <= 32'h0;
			blk_count <= 8'h0;
		end
		else if (rpt_valid)
		begin
			blk_info <= rpt_info;
			blk_count <= blk_count + 8'h1;
		end
	end
endmodule

/* verif/test_event_status_info_encoder.sv */
// Purpose: self-checking bench for the event status encoder
// Assumes: default parameters, multi-slot, media sensed while open
// Notes:   good reports come from one table, refusals from a second
`timescale 1ns/10ps
module test_event_status_info_encoder
	import esie_pkg::*;
;
	typedef struct packed
	{
		logic [1:0]  cls;
		logic [31:0] regv;
		logic        door;
		logic        med;
		logic [7:0]  qual;
		logic [31:0] info;
	} esie_row_s;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [5:0]  addr = 6'h0;
	logic [31:0] wr_data = 32'h0;
	logic        wr_en = 1'h0;
	logic        rd_en = 1'h0;
	logic        door_open = 1'h0;
	logic        media_sensed = 1'h0;
	logic [31:0] rd_data, rpt_info, blk_info, d;
	logic [7:0]  rpt_status, rpt_sense_key, rpt_sense_code, rpt_qualifier;
	logic [7:0]  blk_count;
	logic        rpt_valid, irq;
	int          n_fail = 0;
	int          check_count = 0;
	int          cycles = 0;
	// class, register word, door, media, qualifier, information field
	esie_row_s rows [11] = '{
		'{2'h1, 32'h0000_0100, 1'h0, 1'h0, 8'h02, 32'h0001_0000},
		'{2'h1, 32'h0000_0201, 1'h0, 1'h0, 8'h02, 32'h0102_0000},
		'{2'h1, 32'h0000_0302, 1'h0, 1'h0, 8'h02, 32'h0203_0000},
		'{2'h2, 32'h0004_0100, 1'h0, 1'h0, 8'h04, 32'h0000_0104},
		'{2'h2, 32'h0002_0201, 1'h1, 1'h0, 8'h04, 32'h0101_0202},
		'{2'h2, 32'h0007_0502, 1'h0, 1'h1, 8'h04, 32'h0202_0507},
		'{2'h2, 32'h0000_ff03, 1'h1, 1'h1, 8'h04, 32'h0303_ff00},
		'{2'h3, 32'h0000_0000, 1'h0, 1'h0, 8'h06, 32'h0000_0000},
		'{2'h3, 32'h1234_0101, 1'h0, 1'h0, 8'h06, 32'h0101_1234},
		'{2'h3, 32'hffff_0200, 1'h0, 1'h0, 8'h06, 32'h0002_ffff},
		'{2'h3, 32'h0001_0301, 1'h0, 1'h0, 8'h06, 32'h0103_0001}};
	// reserved codes and class zero, each must be refused
	logic [33:0] bad [7] = '{{2'h1, 32'h0103}, {2'h1, 32'h0000},
		{2'h1, 32'h0401}, {2'h2, 32'h0004}, {2'h3, 32'h0002},
		{2'h3, 32'h0400}, {2'h0, 32'h0000}};

	esie_encoder i_dut (.clk(clk), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .door_open(door_open),
		.media_sensed(media_sensed), .rpt_valid(rpt_valid),
		.rpt_status(rpt_status), .rpt_sense_key(rpt_sense_key),
		.rpt_sense_code(rpt_sense_code), .rpt_qualifier(rpt_qualifier),
		.rpt_info(rpt_info), .irq(irq));
	esie_host_model i_host (.clk(clk), .rst(rst), .rpt_valid(rpt_valid),
		.rpt_info(rpt_info), .blk_info(blk_info), .blk_count(blk_count));

	always #25 clk = ~clk;

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] got,
		input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("FAIL %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	// a gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] v);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1;
		v = rd_data;
		@(posedge clk);
	endtask

	// returns just after the edge where the report pulse stands
	task automatic send(input logic [1:0] c);
		wr(ESIE_OFS_SEND, {30'h0, c});
		#1;
	endtask

	// hang guard, far above the fewer than 150 cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			results();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1;
		chk("reset irq", 32'(irq), 32'h0);
		chk("reset info", rpt_info, 32'h0);
		rd(ESIE_OFS_CTRL, d);
		chk("reset ctrl", d, 32'h0);
		wr(ESIE_OFS_PWR, 32'h0000_0101);
		send(ESIE_CLS_POWER);
		chk("disabled pulse", 32'(rpt_valid), 32'h0);
		rd(ESIE_OFS_ISTAT, d);
		chk("disabled flag", d & 32'h2, 32'h2);
		wr(ESIE_OFS_ICLR, 32'h1f);
		wr(ESIE_OFS_IEN, 32'h1);
		wr(ESIE_OFS_CTRL, 32'h1);
		foreach (rows[i])
		begin
			door_open <= rows[i].door;
			media_sensed <= rows[i].med;
			wr(ESIE_OFS_SEND + {2'h0, rows[i].cls, 2'h0}, rows[i].regv);
			send(rows[i].cls);
			chk("pulse", 32'(rpt_valid), 32'h1);
			chk("sense", 32'({rpt_status, rpt_sense_key,
				rpt_sense_code}), 32'h0002_067f);
			chk("qualifier", 32'(rpt_qualifier), 32'(rows[i].qual));
			chk("info", rpt_info, rows[i].info);
			chk("info", rpt_info, rows[i].info);
			@(posedge clk);
			#1;
			chk("host block", blk_info, rows[i].info);
		end
		chk("irq set", 32'(irq), 32'h1);
		wr(ESIE_OFS_ICLR, 32'h1f);
		#1;
		chk("irq cleared", 32'(irq), 32'h0);
		wr(ESIE_OFS_IEN, 32'h4);
		foreach (bad[i])
		begin
			if (bad[i][33:32] != 2'h0)
				wr(ESIE_OFS_SEND + {2'h0, bad[i][33:32], 2'h0}, bad[i][31:0]);
			send(bad[i][33:32]);
			chk("refused pulse", 32'(rpt_valid), 32'h0);
		end
		rd(ESIE_OFS_ISTAT, d);
		chk("refused flag", d & 32'h4, 32'h4);
		#1;
		chk("irq refused", 32'(irq), 32'h1);
		wr(ESIE_OFS_IEN, 32'h0);
		#1;
		chk("irq masked", 32'(irq), 32'h0);
		chk("host count", 32'(blk_count), 32'h0b);
		rd(6'h3c, d);
		chk("unmapped", d, 32'h0);
		rd(ESIE_OFS_STATE, d);
		chk("state reg", d, 32'h0000_0b00);
		// a send while busy is dropped; a door move is flagged
		wr(ESIE_OFS_ICLR, 32'h1f);
		wr(ESIE_OFS_BUSY, 32'h0001_0301);
		door_open <= 1'h1;
		wr(ESIE_OFS_SEND, 32'h3);
		wr(ESIE_OFS_SEND, 32'h3);
		rd(ESIE_OFS_ISTAT, d);
		chk("busy flags", d, 32'h19);
		chk("host count", 32'(blk_count), 32'h0c);
		chk("host block", blk_info, 32'h0103_0001);
		// mid-run reset clears enable, count and report fields
		rst <= 1'h1;
		door_open <= 1'h0;
		@(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1;
		chk("rerun info", rpt_info, 32'h0);
		chk("rerun qual", 32'(rpt_qualifier), 32'h0);
		rd(ESIE_OFS_CTRL, d);
		chk("rerun ctrl", d, 32'h0);
		rd(ESIE_OFS_STATE, d);
		chk("rerun state", d, 32'h0);
		results();
	end
endmodule

bind esie_encoder esie_chk u_chk (.*);
